// *** logic/pcw_params.svh ***
// Purpose: constants of the port pin configuration and wake-up block
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes:   port index is address bits 7:5, register index bits 4:2
`ifndef PCW_PARAMS_SVH
`define PCW_PARAMS_SVH

// --------------------------------------------------------------------
// port indices
// --------------------------------------------------------------------
`define PCW_PORT_AD   3'h0
`define PCW_PORT_XT   3'h1
`define PCW_PORT_J    3'h2
`define PCW_PORT_HV   3'h3
`define PCW_PORT_P    3'h4
`define PCW_PORT_S    3'h5
`define PCW_PORT_T    3'h6
`define PCW_PORT_GLB  3'h7

// --------------------------------------------------------------------
// register indices inside a port window
// --------------------------------------------------------------------
`define PCW_REG_DATA  3'h0
`define PCW_REG_DIR   3'h1
`define PCW_REG_PEN   3'h2
`define PCW_REG_PUP   3'h3
`define PCW_REG_IN    3'h4
`define PCW_REG_WEN   3'h5
`define PCW_REG_POL   3'h6
`define PCW_REG_FLAG  3'h7
`define PCW_REG_ASEL  3'h0
`define PCW_REG_PEND  3'h1

// --------------------------------------------------------------------
// pin masks and reset values, one 16-bit lane per port, T leftmost
// --------------------------------------------------------------------
`define PCW_MSK_AD    16'hffff
`define PCW_MSK_2     16'h0003
`define PCW_MSK_8     16'h00ff
`define PCW_RST_PEN   {16'h0000, 16'h00ff, 16'h0000, 16'h0000, 16'h0003, 16'h0003, 16'h0000}
`define PCW_RST_PUP   {16'h0000, 16'h00ff, 16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h0000}

`endif

// *** logic/pcw_pkg.sv ***
// Purpose: types of the port pin configuration and wake-up block
// Assumes: seven ports, each held in a 16-bit lane
// Notes:   unused lane bits stay zero, except oe_n (held at one) and the s1, s2, prev pin samples
package pcw_pkg;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } pcw_wb_req_t;

   typedef struct packed {
      logic [15:0] dout;
      logic [15:0] oe_n;
      logic [15:0] pull_en;
      logic [15:0] pull_up;
   } pcw_pad_t;

   typedef struct packed {
      logic [6:0][15:0] dout;
      logic [6:0][15:0] oe_n;
      logic [6:0][15:0] pen;
      logic [6:0][15:0] pup;
      logic [6:0][15:0] wen;
      logic [6:0][15:0] pol;
      logic [6:0][15:0] flag;
      logic [6:0][15:0] s1;
      logic [6:0][15:0] s2;
      logic [6:0][15:0] prev;
      logic [1:0]       asel;
      logic             ack;
      logic [31:0]      rdat;
      logic             irq;
      logic             wake;
   } pcw_state_t;

endpackage : pcw_pkg

// *** logic/pcw_port.sv ***
// Purpose: per-pin direction, pull and wake-up logic of seven ports
// Assumes: pins asynchronous to i_clk, stop request on i_clk
// Notes:   registers over classic Wishbone, ack one cycle after strobe
// Functional notes
// RULE1: analog port pins: direction and wake each
// RULE2: analog, P, T pulls disabled after reset
// RULE3: crystal pins reset with pull-downs enabled
// RULE4: J pins reset with pull-ups enabled
// RULE5: S pins reset with pull-ups enabled
// RULE6: per-pin pull enable and up/down select
// RULE7: P pins individually wake-capable interrupt inputs
// RULE8: S pins individually wake-capable interrupt inputs
// RULE9: high-voltage pins input-only, wake or analog
// RULE10: edge sets flag, interrupt, wake when stopped
//
// The implementer's own choices: the Wishbone register port and the address map.
`include "pcw_params.svh"

module pcw_port
   import pcw_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   input  wire pcw_wb_req_t      i_wb,
   output logic [31:0]           o_wb_dat,
   output logic                  o_wb_ack,
   input  wire logic [6:0][15:0] i_pad_in,
   output pcw_pad_t [6:0]        o_pad,
   output logic [1:0]            o_hv_analog_sel,
   input  wire logic             i_stop_mode,
   output logic                  o_irq,
   output logic                  o_wake
);

   // -----------------------------------------------------------------
   // reset image and pin capability masks
   // -----------------------------------------------------------------
   localparam pcw_state_t RST = '{
      oe_n : '1,
      pen  : `PCW_RST_PEN,
      pup  : `PCW_RST_PUP,
      default : '0
   };

   function automatic logic [15:0] pin_mask(input logic [2:0] p);
      case (p)
         `PCW_PORT_AD : pin_mask = `PCW_MSK_AD;
         `PCW_PORT_XT,
         `PCW_PORT_J,
         `PCW_PORT_HV : pin_mask = `PCW_MSK_2;
         `PCW_PORT_P,
         `PCW_PORT_S,
         `PCW_PORT_T  : pin_mask = `PCW_MSK_8;
         default      : pin_mask = '0;
      endcase
   endfunction : pin_mask

   function automatic logic [15:0] wake_mask(input logic [2:0] p);
      case (p)
         `PCW_PORT_AD,
         `PCW_PORT_HV,
         `PCW_PORT_P,
         `PCW_PORT_S : wake_mask = pin_mask(p);
         default     : wake_mask = '0;
      endcase
   endfunction : wake_mask

   // output drive and pulls: every port except the input-only one
   function automatic logic [15:0] drive_mask(input logic [2:0] p);
      drive_mask = (p == `PCW_PORT_HV) ? 16'h0000 : pin_mask(p);
   endfunction : drive_mask

   pcw_state_t  st_ff;
   pcw_state_t  nxt_st;
   logic        req;
   logic        wr;
   logic [2:0]  a_port;
   logic [2:0]  a_reg;
   logic [15:0] be;
   logic [15:0] wd;
   logic [15:0] ev;
   logic [15:0] clr;
   logic [15:0] rd;
   logic [6:0]  pend;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      req    = i_wb.cyc & i_wb.stb & ~st_ff.ack;
      wr     = req & i_wb.we;
      a_port = i_wb.adr[7:5];
      a_reg  = i_wb.adr[4:2];
      be     = {{8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};
      wd     = i_wb.dat[15:0];
      ev     = '0;
      clr    = '0;
      rd     = '0;
      pend   = '0;
      nxt_st.s1   = i_pad_in;
      nxt_st.s2   = st_ff.s1;
      nxt_st.prev = st_ff.s2;
      for (int p = 0; p < 7; p++) begin
         // edge of the selected polarity on an armed pin
         ev = (st_ff.s2[p] ^ st_ff.prev[p]) & ~(st_ff.s2[p] ^ st_ff.pol[p])
              & st_ff.wen[p];                                            // RULE10
         clr = '0;
         if (wr && a_port == p[2:0]) begin
            case (a_reg)
               `PCW_REG_DATA : nxt_st.dout[p] = (st_ff.dout[p] & ~be)
                                               | (wd & be & drive_mask(p[2:0]));
               `PCW_REG_DIR  : nxt_st.oe_n[p] = (st_ff.oe_n[p] & ~be)
                                               | (~wd & be) | ~drive_mask(p[2:0]); // RULE1 RULE9
               `PCW_REG_PEN  : nxt_st.pen[p]  = (st_ff.pen[p] & ~be)
                                               | (wd & be & drive_mask(p[2:0])); // RULE6
               `PCW_REG_PUP  : nxt_st.pup[p]  = (st_ff.pup[p] & ~be)
                                               | (wd & be & drive_mask(p[2:0])); // RULE6
               `PCW_REG_WEN  : nxt_st.wen[p]  = (st_ff.wen[p] & ~be)
                                               | (wd & be & wake_mask(p[2:0])); // RULE7 RULE8
               `PCW_REG_POL  : nxt_st.pol[p]  = (st_ff.pol[p] & ~be)
                                               | (wd & be & wake_mask(p[2:0]));
               `PCW_REG_FLAG : clr = wd & be;
               default       : clr = '0;
            endcase
         end
         // a new edge wins over a clear in the same cycle
         nxt_st.flag[p] = (st_ff.flag[p] & ~clr) | ev;                  // RULE10
         pend[p] = |(st_ff.flag[p] & st_ff.wen[p]);
      end
      if (wr && a_port == `PCW_PORT_GLB && a_reg == `PCW_REG_ASEL && i_wb.sel[0]) begin
         nxt_st.asel = wd[1:0];                                          // RULE9
      end
      // read side
      if (a_port == `PCW_PORT_GLB) begin
         case (a_reg)
            `PCW_REG_ASEL : rd = {14'h0000, st_ff.asel};
            `PCW_REG_PEND : rd = {9'h000, pend};
            default       : rd = '0;
         endcase
      end else begin
         case (a_reg)
            `PCW_REG_DATA : rd = st_ff.dout[a_port];
            `PCW_REG_DIR  : rd = ~st_ff.oe_n[a_port] & pin_mask(a_port);
            `PCW_REG_PEN  : rd = st_ff.pen[a_port];
            `PCW_REG_PUP  : rd = st_ff.pup[a_port];
            `PCW_REG_IN   : rd = st_ff.s2[a_port] & pin_mask(a_port);
            `PCW_REG_WEN  : rd = st_ff.wen[a_port];
            `PCW_REG_POL  : rd = st_ff.pol[a_port];
            `PCW_REG_FLAG : rd = st_ff.flag[a_port];
            default       : rd = '0;
         endcase
      end
      nxt_st.ack  = req;
      nxt_st.rdat = (req && !i_wb.we) ? {16'h0000, rd} : 32'h0000_0000;
      nxt_st.irq  = |(nxt_st.flag & nxt_st.wen);                         // RULE10
      nxt_st.wake = nxt_st.irq & i_stop_mode;                            // RULE10
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_ff <= RST;                                  // RULE2 RULE3 RULE4 RULE5
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -----------------------------------------------------------------
   // outputs straight from the state register
   // -----------------------------------------------------------------
   for (genvar g = 0; g < 7; g++) begin : g_pad
      assign o_pad[g] = '{dout    : st_ff.dout[g],
                          oe_n    : st_ff.oe_n[g],
                          pull_en : st_ff.pen[g],
                          pull_up : st_ff.pup[g]};
   end
   assign o_wb_dat        = st_ff.rdat;
   assign o_wb_ack        = st_ff.ack;
   assign o_hv_analog_sel = st_ff.asel;
   assign o_irq           = st_ff.irq;
   assign o_wake          = st_ff.wake;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic wr_seen_ff;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_seen_ff <= 1'b0;
      end else if (wr) begin
         wr_seen_ff <= 1'b1;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   rst_pull_off_a: assert property (!wr_seen_ff |-> o_pad[0].pull_en == 16'h0000 // RULE2
      && o_pad[4].pull_en == 16'h0000 && o_pad[6].pull_en == 16'h0000)
      else $error("pulls of analog, P or T port enabled before any write");
   rst_xtal_down_a: assert property (!wr_seen_ff |->                      // RULE3
      o_pad[1].pull_en == 16'h0003 && o_pad[1].pull_up == 16'h0000)
      else $error("crystal pins lost pull-down before any write");
   rst_j_up_a: assert property (!wr_seen_ff |->                           // RULE4
      o_pad[2].pull_en == 16'h0003 && o_pad[2].pull_up == 16'h0003)
      else $error("J pins lost pull-up before any write");
   rst_s_up_a: assert property (!wr_seen_ff |->                           // RULE5
      o_pad[5].pull_en == 16'h00ff && o_pad[5].pull_up == 16'h00ff)
      else $error("S pins lost pull-up before any write");
   pull_write_a: assert property (wr && a_port == `PCW_PORT_AD             // RULE6
      && a_reg == `PCW_REG_PEN && i_wb.sel[1:0] == 2'b11
      |=> o_pad[0].pull_en == $past(wd) ##1 o_wb_ack == 1'b0)
      else $error("analog port pull enable not taken from write");
   dir_write_a: assert property (wr && a_port == `PCW_PORT_AD              // RULE1
      && a_reg == `PCW_REG_DIR && i_wb.sel[1:0] == 2'b11
      |=> o_pad[0].oe_n == ~$past(wd))
      else $error("analog port direction not taken from write");
   hv_input_a: assert property (o_pad[3].oe_n == 16'hffff                 // RULE9
      && o_pad[3].pull_en == 16'h0000)
      else $error("high-voltage pin driven or pulled");
   p_wake_a: assert property (st_ff.wen[4][7] && !st_ff.pol[4][7]         // RULE7
      && st_ff.prev[4][7] && !st_ff.s2[4][7] |=> st_ff.flag[4][7] && o_irq)
      else $error("P pin falling edge did not flag and interrupt");
   s_wake_a: assert property (st_ff.wen[5][0] && !st_ff.pol[5][0]         // RULE8
      && st_ff.prev[5][0] && !st_ff.s2[5][0] |=> st_ff.flag[5][0] && o_irq)
      else $error("S pin falling edge did not flag and interrupt");
   stop_wake_a: assert property (o_irq && i_stop_mode |=> o_wake          // RULE10
      || !o_irq)
      else $error("pending interrupt in stop gave no wake");
   ack_once_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");
   ack_answer_a: assert property (req |=> o_wb_ack)
      else $error("request not answered one cycle later");
   rdat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
      else $error("read data not zero outside acknowledge");

   dout_write_a: assert property (wr && a_port == `PCW_PORT_AD            // RULE1
      && a_reg == `PCW_REG_DATA && i_wb.sel[1:0] == 2'b11
      |=> o_pad[0].dout == $past(wd))
      else $error("analog port output value not taken from write");
   pup_write_a: assert property (wr && a_port == `PCW_PORT_AD             // RULE6
      && a_reg == `PCW_REG_PUP && i_wb.sel[1:0] == 2'b11
      |=> o_pad[0].pull_up == $past(wd))
      else $error("analog port pull select not taken from write");

   // -----------------------------------------------------------------
   // pin capability checks
   // -----------------------------------------------------------------
   // bits a port lacks are dropped on write
   no_wake_cap_a: assert property (st_ff.wen[1] == 16'h0000               // RULE7 RULE8
      && st_ff.wen[2] == 16'h0000 && st_ff.wen[6] == 16'h0000)
      else $error("wake enabled on a port without wake inputs");
   xt_pins_a: assert property (o_pad[1].oe_n[15:2] == 14'h3fff            // RULE3
      && o_pad[1].pull_en[15:2] == 14'h0000)
      else $error("crystal port drives or pulls a missing pin");
   hv_no_drive_a: assert property (o_pad[3].dout == 16'h0000              // RULE9
      && o_pad[3].pull_up == 16'h0000)
      else $error("high-voltage pin has output or pull value");
   asel_write_a: assert property (wr && a_port == `PCW_PORT_GLB            // RULE9
      && a_reg == `PCW_REG_ASEL && i_wb.sel[0]
      |=> o_hv_analog_sel == $past(wd[1:0]))
      else $error("analog routing of high-voltage pins not taken from write");

   // -----------------------------------------------------------------
   // wake event checks
   // -----------------------------------------------------------------
   // one armed pin per wake-capable port, as the bench arms them
   ad_wake_a: assert property (st_ff.wen[0][15] && st_ff.pol[0][15]       // RULE1
      && !st_ff.prev[0][15] && st_ff.s2[0][15] |=> st_ff.flag[0][15] && o_irq)
      else $error("analog pin rising edge did not flag and interrupt");
   hv_wake_a: assert property (st_ff.wen[3][1] && st_ff.pol[3][1]         // RULE9
      && !st_ff.prev[3][1] && st_ff.s2[3][1] |=> st_ff.flag[3][1] && o_irq)
      else $error("high-voltage pin rising edge did not flag and interrupt");

   p_armed_a: assert property (!st_ff.wen[4][7] && !st_ff.flag[4][7]      // RULE7
      |=> !st_ff.flag[4][7])
      else $error("disarmed P pin raised its flag");
   s_armed_a: assert property (!st_ff.wen[5][0] && !st_ff.flag[5][0]      // RULE8
      |=> !st_ff.flag[5][0])
      else $error("disarmed S pin raised its flag");

   // clear checked on a quiet pin only: a fresh edge keeps the flag
   p_clear_a: assert property (wr && a_port == `PCW_PORT_P                // RULE10
      && a_reg == `PCW_REG_FLAG && i_wb.sel[0] && i_wb.dat[7]
      && st_ff.prev[4][7] == st_ff.s2[4][7] |=> !st_ff.flag[4][7])
      else $error("P pin flag not cleared by a written one");
   flag_hold_a: assert property (st_ff.flag[5][0]                         // RULE10
      && !(wr && a_port == `PCW_PORT_S && a_reg == `PCW_REG_FLAG) |=> st_ff.flag[5][0])
      else $error("S pin flag dropped without a clear");

   irq_level_a: assert property (o_irq == |(st_ff.flag & st_ff.wen))     // RULE10
      else $error("interrupt level differs from armed flags");
   pend_sum_a: assert property (o_irq == |pend)                          // RULE10
      else $error("pending summary differs from interrupt level");
   wake_idle_a: assert property (!i_stop_mode |=> !o_wake)                // RULE10
      else $error("wake raised outside stop");

   wake_cov_c: cover property (o_irq ##1 i_stop_mode ##1 o_wake);
   clear_cov_c: cover property (o_irq && wr && a_reg == `PCW_REG_FLAG ##1 !o_irq);
   read_cov_c: cover property (req && !i_wb.we && a_reg == `PCW_REG_IN ##1 o_wb_ack);
   pend_cov_c: cover property (req && !i_wb.we && a_port == `PCW_PORT_GLB
      && a_reg == `PCW_REG_PEND);
   edge_cov_c: cover property (st_ff.flag[4][7] && o_wake);

endmodule : pcw_port

// *** verification/pcw_board.sv ***
// Purpose: board circuitry model that settles every pin level
// Assumes: bench switches external sources on and off per pin
// Notes:   an undriven pin without pull toggles every cycle
module pcw_board
   import pcw_pkg::*;
(
   input  wire logic             i_clk,
   input  wire pcw_pad_t [6:0]   i_pad,
   input  wire logic [6:0][15:0] i_ext_en,
   input  wire logic [6:0][15:0] i_ext_val,
   output logic [6:0][15:0]      o_level
);
   timeunit 1ns;
   timeprecision 1ns;

   logic flt_ff = 1'b0;

   always @(posedge i_clk) begin
      flt_ff <= ~flt_ff;
   end

   always_comb begin
      for (int l = 0; l < 7; l++) begin
         for (int b = 0; b < 16; b++) begin
            if (!i_pad[l].oe_n[b]) begin
               o_level[l][b] = i_pad[l].dout[b];
            end
            else if (i_ext_en[l][b]) begin
               o_level[l][b] = i_ext_val[l][b];
            end
            else if (i_pad[l].pull_en[b]) begin
               o_level[l][b] = i_pad[l].pull_up[b];
            end
            else begin
               o_level[l][b] = flt_ff;
            end
         end
      end
   end
endmodule : pcw_board

// *** verification/test_port_pin_config_and_wakeup.sv ***
// Purpose: self-checking bench of the port pin and wake-up block
// Assumes: classic Wishbone master, ack seen at a rising edge
// Notes:   pins come from the board model
module test_port_pin_config_and_wakeup;
   import pcw_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic             clk = 1'b0;
   logic             reset_n;
   pcw_wb_req_t      wb;
   logic [31:0]      wb_dat;
   logic             wb_ack;
   logic [6:0][15:0] pad_in;
   pcw_pad_t [6:0]   pad;
   logic [1:0]       hv_sel;
   logic             stop;
   logic             irq;
   logic             wake;
   logic [6:0][15:0] ext_en;
   logic [6:0][15:0] ext_val;
   int               n_fail;
   int               samples_checked;
   int               cycles = 0;
   localparam logic [15:0] EXP_PEN [7] = '{16'h0000, 16'h0003, 16'h0003, 16'h0000,
                                          16'h0000, 16'h00ff, 16'h0000};
   localparam logic [15:0] EXP_PUP [7] = '{16'h0000, 16'h0000, 16'h0003, 16'h0000,
                                          16'h0000, 16'h00ff, 16'h0000};

   always #5 clk = ~clk;

   pcw_port uut (.i_clk(clk), .i_reset_n(reset_n), .i_wb(wb), .o_wb_dat(wb_dat),
      .o_wb_ack(wb_ack), .i_pad_in(pad_in), .o_pad(pad), .o_hv_analog_sel(hv_sel),
      .i_stop_mode(stop), .o_irq(irq), .o_wake(wake));
   pcw_board board (.i_clk(clk), .i_pad(pad), .i_ext_en(ext_en), .i_ext_val(ext_val),
      .o_level(pad_in));

   // --------------------------------------------------------------
   // tasks
   // --------------------------------------------------------------
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end
      else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] rd);
      @(posedge clk);
      wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h3, dat: {16'h0000, d}};
      do @(posedge clk); while (wb_ack !== 1'b1);
      rd = wb_dat;
      wb <= '0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, rd);
   endtask : wr

   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 16'h0000, rd);
      check(what, rd, exp);
   endtask : rdc

   // edge on one pin: ignored while disabled, then flag, mask, clear
   task automatic wake_test(input int l, input int b, input logic pol, input logic stp);
      logic [15:0] m;
      m = 16'h0001 << b;
      ext_val[l][b] <= ~pol;
      ext_en[l][b] <= 1'b1;
      stop <= stp;
      repeat (4) @(posedge clk);
      ext_val[l][b] <= pol;
      repeat (5) @(posedge clk);
      check("irq_disabled", irq, 1'b0);
      ext_val[l][b] <= ~pol;
      wr(8'(l * 32 + 24), pol ? m : 16'h0000);
      wr(8'(l * 32 + 20), m);
      ext_val[l][b] <= pol;
      repeat (5) @(posedge clk);
      check("irq_set", irq, 1'b1);
      check("wake_set", wake, stp);
      rdc("flag", 8'(l * 32 + 28), m);
      rdc("pend", 8'he4, 32'h0000_0001 << l);
      wr(8'(l * 32 + 20), 16'h0000);
      repeat (3) @(posedge clk);
      check("irq_masked", irq, 1'b0);
      wr(8'(l * 32 + 20), m);
      repeat (3) @(posedge clk);
      check("irq_unmasked", irq, 1'b1);
      wr(8'(l * 32 + 28), m);
      repeat (3) @(posedge clk);
      check("irq_clear", irq, 1'b0);
      check("wake_clear", wake, 1'b0);
      wr(8'(l * 32 + 20), 16'h0000);
      ext_en[l][b] <= 1'b0;
      stop <= 1'b0;
   endtask : wake_test

   // --------------------------------------------------------------
   // sequence
   // --------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      wb = '0;
      stop = 1'b0;
      ext_en = '0;
      ext_val = '0;
      n_fail = 0;
      samples_checked = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      for (int l = 0; l < 7; l++) begin
         check("oe_n_rst", pad[l].oe_n, 16'hffff);
         check("pull_en_rst", pad[l].pull_en, EXP_PEN[l]);
         check("pull_up_rst", pad[l].pull_up, EXP_PUP[l]);
         rdc("pull_en_reg", 8'(l * 32 + 8), EXP_PEN[l]);
      end
      wr(8'h04, 16'ha5a5);
      wr(8'h00, 16'h5af0);
      wr(8'h08, 16'h5a5a);
      wr(8'h0c, 16'h0f0f);
      check("ad_oe_n", pad[0].oe_n, 16'h5a5a);
      check("ad_dout", pad[0].dout, 16'h5af0);
      check("ad_pull_en", pad[0].pull_en, 16'h5a5a);
      check("ad_pull_up", pad[0].pull_up, 16'h0f0f);
      repeat (3) @(posedge clk);
      rdc("ad_in", 8'h10, 16'h0aaa);
      wr(8'h04, 16'h0000);
      wr(8'h24, 16'h0001);
      wr(8'h2c, 16'h0002);
      check("xt_oe_n", pad[1].oe_n, 16'hfffe);
      check("xt_pull_up", pad[1].pull_up, 16'h0002);
      wr(8'h64, 16'h0003);
      wr(8'h68, 16'h0003);
      wr(8'h60, 16'h0003);
      wr(8'h6c, 16'h0003);
      check("hv_oe_n", pad[3].oe_n, 16'hffff);
      check("hv_pull_en", pad[3].pull_en, 16'h0000);
      check("hv_dout", pad[3].dout, 16'h0000);
      check("hv_pull_up", pad[3].pull_up, 16'h0000);
      rdc("hv_dir", 8'h64, 32'h0000_0000);
      wr(8'h54, 16'h0003);
      rdc("j_wen", 8'h54, 32'h0000_0000);
      wr(8'he0, 16'h0002);
      check("hv_analog", hv_sel, 2'b10);
      rdc("hv_analog_reg", 8'he0, 32'h0000_0002);
      rdc("unmapped", 8'hf0, 32'h0000_0000);
      wake_test(0, 15, 1'b1, 1'b0);
      wake_test(3, 1, 1'b1, 1'b1);
      wake_test(4, 7, 1'b0, 1'b1);
      wake_test(5, 0, 1'b0, 1'b0);
      end_sim();
   end
endmodule : test_port_pin_config_and_wakeup
